/* File: core_agu_model.sv */
/* far-side model: the core's address generators, one request per call
   assumes the caller reads the answer one edge after the request */
`timescale 1ns/1ps
`default_nettype none
module core_agu_model (
    input wire logic clk,
    output modulo_pkg::addr_req_t req [modulo_pkg::CHANNELS]
);
    initial begin
        for (int i = 0; i < modulo_pkg::CHANNELS; i++) begin
            req[i] = '0;
        end
    end
    task automatic drive(input int ch, input modulo_pkg::addr_req_t r);
        modulo_pkg::addr_req_t idle;
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge clk);
        req[ch] <= r;
        @(posedge clk);
        // released fields never keep the last value
        req[ch] <= idle;
    endtask
endmodule // core_agu_model
`default_nettype wire

/* File: modulo_addressing.sv */
/*
 * Circular buffer address unit: APB register file (control, X and Y
 * boundaries, direction, status) and three registered address channels
 * (X read, X write, Y) that wrap the core's next effective address.
 * Assumes the core presents one request per channel per cycle, holding
 * the pointer number it is updating, and accepts the answer one cycle on.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - one circular buffer in X space (also program space), one in Y space.
// - wrapping applies alike to data-space and program-space accesses.
// - a general buffer runs one way; direction picks which boundary is checked.
// - power-of-two length buffers check both lower and upper boundaries.
// - four separate 16-bit writable start and end boundary registers; Y start bit 0 is kept at 0 and Y end bit 0 at 1 whatever is written.
// - Y space addresses are word sized; the lowest bit is always clear.
// - no length register; length is end minus start plus one.
// - buffers up to 32K words, 64 Kbytes, are supported.
// - X select of 1111 disables wrapping for X read and write generators.
// - Y select of 1111 disables wrapping for the Y generator.
// - X select in control bits 3:0, X enable bit 15.
// - Y select in control bits 7:4, Y enable bit 14.
module modulo_addressing (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire modulo_pkg::addr_req_t req [modulo_pkg::CHANNELS],
    output modulo_pkg::addr_resp_t resp [modulo_pkg::CHANNELS]
);
    logic rstMeta;
    logic rstSyncN;

    logic [15:0] modulo_control;
    logic [15:0] x_buffer_start;
    logic [15:0] x_buffer_end;
    logic [15:0] y_buffer_start;
    logic [15:0] y_buffer_end;
    logic [1:0] direction;
    logic xWrapped;
    logic yWrapped;

    logic [3:0] x_pointer_select;
    logic [3:0] y_pointer_select;
    logic x_circular_enable;
    logic y_circular_enable;
    logic xActive;
    logic yActive;

    modulo_pkg::buffer_cfg_t xCfg;
    modulo_pkg::buffer_cfg_t yCfg;

    logic setupPhase;
    logic writeTaken;
    logic writeLow;
    logic writeHigh;
    logic mapped;
    logic [31:0] readValue;
    logic [15:0] statusValue;
    logic clearXWrapped;
    logic clearYWrapped;

    logic [15:0] chanAddr [modulo_pkg::CHANNELS];
    logic chanWrapped [modulo_pkg::CHANNELS];
    logic chanLengthOk [modulo_pkg::CHANNELS];
    logic chanHit [modulo_pkg::CHANNELS];

    // reset released through two flops so every register leaves reset together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // control field decode
    always_comb begin
        x_pointer_select = modulo_control[modulo_pkg::X_SELECT_LSB +: modulo_pkg::SELECT_WIDTH];
        y_pointer_select = modulo_control[modulo_pkg::Y_SELECT_LSB +: modulo_pkg::SELECT_WIDTH];
        x_circular_enable = modulo_control[modulo_pkg::X_ENABLE_BIT];
        y_circular_enable = modulo_control[modulo_pkg::Y_ENABLE_BIT];
        xActive = x_circular_enable && (x_pointer_select != modulo_pkg::NO_POINTER);
        yActive = y_circular_enable && (y_pointer_select != modulo_pkg::NO_POINTER);
    end

    // one buffer per space: X serves both generators and program space
    always_comb begin
        xCfg.start = x_buffer_start;
        xCfg.finish = x_buffer_end;
        xCfg.active = xActive;
        xCfg.down = direction[modulo_pkg::X_DOWN_BIT];
        yCfg.start = y_buffer_start;
        yCfg.finish = y_buffer_end;
        yCfg.active = yActive;
        yCfg.down = direction[modulo_pkg::Y_DOWN_BIT];
    end

    // APB decode
    always_comb begin
        setupPhase = psel && !penable && !pready;
        writeTaken = psel && penable && pready && pwrite && !pslverr;
        writeLow = writeTaken && pstrb[0];
        writeHigh = writeTaken && pstrb[1];
    end

    // write-one-to-clear on status; writing zero leaves the flags alone
    always_comb begin
        clearXWrapped = writeLow && (paddr == modulo_pkg::OFS_STATUS)
            && pwdata[modulo_pkg::ST_X_WRAPPED];
        clearYWrapped = writeLow && (paddr == modulo_pkg::OFS_STATUS)
            && pwdata[modulo_pkg::ST_Y_WRAPPED];
    end

    // status is assembled live; only the wrap flags hold state
    always_comb begin
        statusValue = 16'h0000;
        statusValue[modulo_pkg::ST_X_ACTIVE] = xActive;
        statusValue[modulo_pkg::ST_Y_ACTIVE] = yActive;
        statusValue[modulo_pkg::ST_X_LEN_OK] = chanLengthOk[modulo_pkg::CH_X_READ];
        statusValue[modulo_pkg::ST_Y_LEN_OK] = chanLengthOk[modulo_pkg::CH_Y];
        statusValue[modulo_pkg::ST_X_WRAPPED] = xWrapped;
        statusValue[modulo_pkg::ST_Y_WRAPPED] = yWrapped;
    end

    // unmapped offsets read zero and are refused with pslverr
    always_comb begin
        mapped = 1'b1;
        readValue = 32'h00000000;
        if (paddr == modulo_pkg::OFS_CONTROL) begin
            readValue = {16'h0000, modulo_control};
        end else if (paddr == modulo_pkg::OFS_X_START) begin
            readValue = {16'h0000, x_buffer_start};
        end else if (paddr == modulo_pkg::OFS_X_END) begin
            readValue = {16'h0000, x_buffer_end};
        end else if (paddr == modulo_pkg::OFS_Y_START) begin
            readValue = {16'h0000, y_buffer_start};
        end else if (paddr == modulo_pkg::OFS_Y_END) begin
            readValue = {16'h0000, y_buffer_end};
        end else if (paddr == modulo_pkg::OFS_DIRECTION) begin
            readValue = {30'h00000000, direction};
        end else if (paddr == modulo_pkg::OFS_STATUS) begin
            readValue = {16'h0000, statusValue};
        end else begin
            mapped = 1'b0;
        end
    end

    // one wait-free access phase: answer registered during the setup cycle
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && !mapped;
        end
    end

    // read data holds until the next read, so a late sampler still sees it
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prdata <= 32'h00000000;
        end else if (setupPhase && !pwrite) begin
            prdata <= readValue;
        end
    end

    // control bits 13:8 belong to other addressing modes and are not kept here
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            modulo_control <= modulo_pkg::CONTROL_RESET;
        end else if (paddr == modulo_pkg::OFS_CONTROL) begin
            if (writeLow) begin
                modulo_control[7:0] <= pwdata[7:0];
            end
            if (writeHigh) begin
                modulo_control[15:14] <= pwdata[15:14];
            end
        end
    end

    // four independent boundary registers, no length register
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            x_buffer_start <= modulo_pkg::BOUNDARY_RESET;
        end else if (paddr == modulo_pkg::OFS_X_START) begin
            if (writeLow) x_buffer_start[7:0] <= pwdata[7:0];
            if (writeHigh) x_buffer_start[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            x_buffer_end <= modulo_pkg::BOUNDARY_RESET;
        end else if (paddr == modulo_pkg::OFS_X_END) begin
            if (writeLow) x_buffer_end[7:0] <= pwdata[7:0];
            if (writeHigh) x_buffer_end[15:8] <= pwdata[15:8];
        end
    end

    // Y boundaries are word addresses: start is even, end is the odd last byte
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            y_buffer_start <= modulo_pkg::BOUNDARY_RESET;
        end else if (paddr == modulo_pkg::OFS_Y_START) begin
            if (writeLow) y_buffer_start[7:0] <= {pwdata[7:1], 1'b0};
            if (writeHigh) y_buffer_start[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            y_buffer_end <= modulo_pkg::BOUNDARY_RESET;
        end else if (paddr == modulo_pkg::OFS_Y_END) begin
            if (writeLow) y_buffer_end[7:0] <= {pwdata[7:1], 1'b1};
            if (writeHigh) y_buffer_end[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            direction <= modulo_pkg::DIRECTION_RESET;
        end else if (writeLow && paddr == modulo_pkg::OFS_DIRECTION) begin
            direction <= pwdata[1:0];
        end
    end

    // sticky wrap flags: a wrap in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            xWrapped <= 1'b0;
        end else if (chanHit[modulo_pkg::CH_X_READ] || chanHit[modulo_pkg::CH_X_WRITE]) begin
            xWrapped <= 1'b1;
        end else if (clearXWrapped) begin
            xWrapped <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            yWrapped <= 1'b0;
        end else if (chanHit[modulo_pkg::CH_Y]) begin
            yWrapped <= 1'b1;
        end else if (clearYWrapped) begin
            yWrapped <= 1'b0;
        end
    end

    // per-channel wrap: X read, X write share the X buffer, Y has its own
    for (genvar g = 0; g < modulo_pkg::CHANNELS; g++) begin : gChannel
        localparam bit IS_Y = (g == modulo_pkg::CH_Y);
        modulo_pkg::buffer_cfg_t cfg;
        logic selected;
        logic wordAccess;

        always_comb begin
            cfg = IS_Y ? yCfg : xCfg;
            // only the chosen pointer wraps; frame and stack pointers are software's call
            selected = req[g].pointer == (IS_Y ? y_pointer_select : x_pointer_select);
            cfg.active = cfg.active && selected;
        end

        // Y is word-only whatever the core asks, so bit 0 never leaks out
        assign wordAccess = IS_Y ? 1'b1 : req[g].wordAccess;

        modulo_wrap uWrap (
            .cfg(cfg),
            .current(req[g].current),
            .next(req[g].next),
            .wordAccess(wordAccess),
            .addr(chanAddr[g]),
            .wrapped(chanWrapped[g]),
            .lengthOk(chanLengthOk[g])
        );

        assign chanHit[g] = req[g].valid && chanWrapped[g];

        // program-space requests take the same path as data requests
        always_ff @(posedge clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
                resp[g] <= '0;
            end else begin
                resp[g].valid <= req[g].valid;
                resp[g].addr <= chanAddr[g];
                resp[g].wrapped <= chanHit[g];
                resp[g].programSpace <= req[g].programSpace;
            end
        end
    end

endmodule // modulo_addressing
`default_nettype wire

/* File: modulo_checker.sv */
/* concurrent checks on the ports of modulo_addressing, bound below
   assumes control writes use full byte strobes */
`timescale 1ns/1ps
`default_nettype none
module modulo_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire modulo_pkg::addr_req_t req [modulo_pkg::CHANNELS],
    input wire modulo_pkg::addr_resp_t resp [modulo_pkg::CHANNELS]
);
    logic [15:0] ctl;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow of the control word, so wrap gating can be judged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= modulo_pkg::CONTROL_RESET;
        end else if (psel && penable && pready && pwrite && paddr == modulo_pkg::OFS_CONTROL) begin
            ctl <= pwdata[15:0];
        end
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_error_unmapped: assert property (psel && !penable && paddr > modulo_pkg::OFS_STATUS
        |=> pslverr && pready) else $error("unmapped access not refused");
    a_resp_follows_req: assert property (1'b1 |-> resp[1].valid == $past(req[1].valid))
        else $error("answer not one cycle after request");
    a_y_word_only: assert property (resp[2].valid |-> !resp[2].addr[0])
        else $error("odd y address");
    a_x_wrap_gated: assert property (resp[0].wrapped |-> $past(ctl[15])
        && $past(ctl[3:0]) != modulo_pkg::NO_POINTER && $past(req[0].pointer) == $past(ctl[3:0]))
        else $error("x wrapped while disabled");
    a_y_wrap_gated: assert property (resp[2].wrapped |-> $past(ctl[14])
        && $past(ctl[7:4]) != modulo_pkg::NO_POINTER && $past(req[2].pointer) == $past(ctl[7:4]))
        else $error("y wrapped while disabled");
    a_plain_pass: assert property (resp[0].valid && !resp[0].wrapped
        && !$past(req[0].wordAccess) |-> resp[0].addr == $past(req[0].next))
        else $error("unwrapped address altered");
    a_space_echo: assert property (resp[0].valid
        |-> resp[0].programSpace == $past(req[0].programSpace)) else $error("space not echoed");
    c_x_wrap: cover property (resp[0].wrapped);
    c_y_wrap: cover property (resp[2].wrapped);
    c_refused: cover property (pslverr);
endmodule // modulo_checker
bind modulo_addressing modulo_checker chk (.clk(clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .resp(resp));
`default_nettype wire

/* File: modulo_circular_addressing_tb.sv */
/* self-checking bench for the circular buffer address unit
   assumes modulo_pkg, modulo_addressing, core_agu_model and the checker */
`timescale 1ns/1ps
`default_nettype none
module modulo_circular_addressing_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    modulo_pkg::addr_req_t req [modulo_pkg::CHANNELS];
    modulo_pkg::addr_resp_t resp [modulo_pkg::CHANNELS];
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int totalChecks = 0;
    int xs, xe, ys, ye, dir, ctl, ch, c, n;
    always #2.5 clk = ~clk;
    modulo_addressing dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req(req), .resp(resp));
    core_agu_model core (.clk(clk), .req(req));
    task automatic finishTest;
        if (fails == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkResp(input int k, input logic [18:0] exp);
        totalChecks++;
        if ({resp[k].valid, resp[k].programSpace, resp[k].wrapped, resp[k].addr} !== exp) begin
            fails++;
            $display("[FAIL] %0t channel %0d address expected %h", $time, k, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask
    task automatic cfg(input int a, input int b, input int y0, input int y1, input int d, int f);
        xs = a;
        xe = b;
        ys = y0 & 'hfffe;
        ye = y1 | 1;
        dir = d;
        ctl = f & 'hc0ff;
        apb(1'b1, modulo_pkg::OFS_X_START, a);
        apb(1'b1, modulo_pkg::OFS_X_END, b);
        apb(1'b1, modulo_pkg::OFS_Y_START, y0);
        apb(1'b1, modulo_pkg::OFS_Y_END, y1);
        apb(1'b1, modulo_pkg::OFS_DIRECTION, d);
        apb(1'b1, modulo_pkg::OFS_CONTROL, f);
    endtask
    // expected final address: {wrapped, address}
    function automatic logic [16:0] model(input int k, p, cur, nx, w);
        int s, e, len, a, wr, dn;
        bit p2;
        s = k == 2 ? ys : xs;
        e = k == 2 ? ye : xe;
        dn = (dir >> (k == 2)) & 1;
        len = e - s + 1;
        p2 = (len & (len - 1)) == 0;
        a = nx;
        wr = 0;
        if (((ctl >> (k == 2 ? 14 : 15)) & 1) && len > 0
            && ((ctl >> (k == 2 ? 4 : 0)) & 15) != 15 && ((ctl >> (k == 2 ? 4 : 0)) & 15) == p) begin
            if ((p2 || !dn) && nx > e && cur <= e) begin
                a = s;
                wr = 1;
            end else if ((p2 || dn) && nx < s && cur >= s) begin
                a = e;
                wr = 1;
            end
        end
        if (w) a = a & 'hfffe;
        return {wr[0], a[15:0]};
    endfunction
    task automatic agu(input int k, p, cur, nx, w, ps);
        core.drive(k, '{1'b1, p[3:0], cur[15:0], nx[15:0], w[0], ps[0]});
        #1;
        chkResp(k, {1'b1, ps[0], model(k, p, cur, nx, w)});
    endtask
    initial begin
        #20us;
        fails++;
        finishTest();
    end
    initial begin
        void'($urandom(48));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdChk(modulo_pkg::OFS_CONTROL, 32'h00ff);
        for (int a = 4; a <= 'h14; a += 4) rdChk(a[7:0], 32'h0);
        rdChk(modulo_pkg::OFS_STATUS, 32'hc);
        apb(1'b1, 8'h20, 32'hffff);
        chk({31'h0, err}, 32'h1);
        cfg('h1000, 'h10fb, 'h2001, 'h20fe, 0, 'hff53);
        rdChk(modulo_pkg::OFS_CONTROL, 32'hc053);
        rdChk(modulo_pkg::OFS_Y_START, 32'h2000);
        rdChk(modulo_pkg::OFS_Y_END, 32'h20ff);
        agu(0, 3, 'h10fa, 'h10fc, 0, 0);
        agu(1, 3, 'h10fa, 'h10fc, 0, 0);
        agu(0, 3, 'h10fa, 'h10fd, 0, 1);
        agu(0, 3, 'h1000, 'h0fff, 0, 0);
        agu(0, 4, 'h10fa, 'h10fc, 0, 0);
        agu(2, 5, 'h2000, 'h1ffe, 1, 0);
        agu(2, 5, 'h20fe, 'h2100, 1, 0);
        rdChk(modulo_pkg::OFS_STATUS, 32'h3f);
        apb(1'b1, modulo_pkg::OFS_STATUS, 32'h30);
        rdChk(modulo_pkg::OFS_STATUS, 32'hf);
        cfg('h1000, 'h10fb, 'h2000, 'h20ff, 1, 'hc053);
        agu(0, 3, 'h1000, 'h0ffe, 0, 0);
        agu(0, 3, 'h10fa, 'h10fc, 0, 0);
        cfg('h1000, 'h10fb, 'h2000, 'h20ff, 0, 'hc0ff);
        agu(1, 15, 'h10fa, 'h10fc, 0, 0);
        agu(2, 15, 'h20fe, 'h2100, 1, 0);
        cfg('h1000, 'h10fb, 'h2000, 'h20ff, 0, 'h0053);
        agu(0, 3, 'h10fa, 'h10fc, 0, 0);
        agu(2, 5, 'h20fe, 'h2100, 1, 0);
        cfg('h3000, 'h2000, 'h2000, 'h20ff, 0, 'hc053);
        apb(1'b0, modulo_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h0);
        cfg('h0000, 'hffff, 'h2000, 'h20ff, 0, 'hc053);
        apb(1'b0, modulo_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        cfg('h1000, 'h10fb, 'h2000, 'h20ff, $urandom % 4, 'hc053);
        repeat (200) begin
            ch = $urandom % 3;
            c = ch == 2 ? ys + ($urandom % 128) * 2 : xs + $urandom % 252;
            n = c + ($urandom % 2 ? 2 : -2) * (1 + $urandom % 2);
            // pointers 14 and 15 stay with the stack
            agu(ch, ch == 2 ? 5 : $urandom % 14, c, n, ch == 2, $urandom % 2);
        end
        finishTest();
    end
endmodule // modulo_circular_addressing_tb
`default_nettype wire

/* File: modulo_pkg.sv */
/*
 * Shared constants and carrier types for the circular-buffer address unit:
 * register offsets, control field positions, reset values and the request
 * and answer structs exchanged with the core's address generators.
 * Assumes a 16-bit data address space and a 32-bit APB register bus.
 */
`default_nettype none
package modulo_pkg;

    // register byte offsets on the APB bus
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_X_START = 8'h04;
    localparam logic [7:0] OFS_X_END = 8'h08;
    localparam logic [7:0] OFS_Y_START = 8'h0c;
    localparam logic [7:0] OFS_Y_END = 8'h10;
    localparam logic [7:0] OFS_DIRECTION = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // modulo_control fields
    localparam int X_SELECT_LSB = 0;
    localparam int Y_SELECT_LSB = 4;
    localparam int SELECT_WIDTH = 4;
    localparam int X_ENABLE_BIT = 15;
    localparam int Y_ENABLE_BIT = 14;
    localparam logic [3:0] NO_POINTER = 4'hf;

    // direction register fields
    localparam int X_DOWN_BIT = 0;
    localparam int Y_DOWN_BIT = 1;

    // status register fields
    localparam int ST_X_ACTIVE = 0;
    localparam int ST_Y_ACTIVE = 1;
    localparam int ST_X_LEN_OK = 2;
    localparam int ST_Y_LEN_OK = 3;
    localparam int ST_X_WRAPPED = 4;
    localparam int ST_Y_WRAPPED = 5;

    // reset values
    localparam logic [15:0] CONTROL_RESET = 16'h00ff;
    localparam logic [15:0] BOUNDARY_RESET = 16'h0000;
    localparam logic [1:0] DIRECTION_RESET = 2'h0;

    // longest buffer: 32K words, 64 Kbytes
    localparam logic [16:0] MAX_LENGTH_BYTES = 17'h10000;

    // address generator channels
    localparam int CHANNELS = 3;
    localparam int CH_X_READ = 0;
    localparam int CH_X_WRITE = 1;
    localparam int CH_Y = 2;

    typedef struct packed {
        logic valid;
        logic [3:0] pointer;
        logic [15:0] current;
        logic [15:0] next;
        logic wordAccess;
        logic programSpace;
    } addr_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic wrapped;
        logic programSpace;
    } addr_resp_t;

    typedef struct packed {
        logic [15:0] start;
        logic [15:0] finish;
        logic active;
        logic down;
    } buffer_cfg_t;

endpackage
`default_nettype wire

/* File: modulo_wrap.sv */
/*
 * Combinational boundary check for one address generator channel.
 * Assumes the caller registers the result and supplies a stable buffer
 * configuration; the length is derived from the two boundaries.
 */
`timescale 1ns/1ps
`default_nettype none
module modulo_wrap (
    input wire modulo_pkg::buffer_cfg_t cfg,
    input wire logic [15:0] current,
    input wire logic [15:0] next,
    input wire logic wordAccess,
    output logic [15:0] addr,
    output logic wrapped,
    output logic lengthOk
);
    logic [16:0] length;
    logic [16:0] lengthLess;
    logic powerOfTwo;
    logic checkHigh;
    logic checkLow;
    logic stepUp;
    logic stepDown;
    logic [15:0] lowMask;

    always_comb begin
        length = {1'b0, cfg.finish} - {1'b0, cfg.start} + 17'h00001;
        lengthLess = length - 17'h00001;
        lengthOk = (cfg.finish >= cfg.start) && (length <= modulo_pkg::MAX_LENGTH_BYTES);
        powerOfTwo = (length & lengthLess) == 17'h00000;
        // power-of-two buffers meet both alignment limits, so both edges are checked
        checkHigh = powerOfTwo || !cfg.down;
        checkLow = powerOfTwo || cfg.down;
        stepUp = next > current;
        stepDown = next < current;
        lowMask = wordAccess ? 16'hfffe : 16'hffff;
        addr = next;
        wrapped = 1'b0;
        if (cfg.active && lengthOk) begin
            if (stepUp && checkHigh && next > cfg.finish && current <= cfg.finish) begin
                addr = cfg.start;
                wrapped = 1'b1;
            end else if (stepDown && checkLow && next < cfg.start && current >= cfg.start) begin
                addr = cfg.finish;
                wrapped = 1'b1;
            end
        end
        addr = addr & lowMask;
    end
endmodule // modulo_wrap
`default_nettype wire
